/* design/pirs_pkg.sv */
// ==========================================================
// Paged register slave constants
package pirs_pkg;
  // Bus address: fixed upper nibble, low bits from straps
  localparam logic [3:0] ADDR_PREFIX = 4'hA;
  localparam int STRAP_W = 3;
  // Register space geometry
  localparam int OFF_W = 7;
  localparam int PAGE_W = 8;
  localparam int PAGE_IDX_W = 3;
  localparam int NUM_PAGES = 8;
  localparam int PAGE_BYTES = 128;
  localparam int MEM_W = PAGE_IDX_W + OFF_W;
  localparam logic [OFF_W-1:0] PAGE_PTR_OFF = 7'h7F;
  localparam logic [OFF_W-1:0] OFF_STEP = 7'h01;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;
  // Two-byte registers: even/odd pairs in one region
  localparam logic [PAGE_W-1:0] MB_PAGE = 8'h02;
  localparam logic [OFF_W-1:0] MB_END = 7'h10;
  // Byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic IDLE_LVL = 1'b1;
  localparam logic DRIVE_LVL = 1'b0;
  // Timing: core clock, bus rates, spike width
  localparam int CLK_NS = 100;
  localparam int SCL_STD_KHZ = 100;
  localparam int SCL_FAST_KHZ = 400;
  localparam int SPIKE_NS = 50;
  localparam int FILT_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] FILT_LIMIT = 2'(FILT_CYC);
  localparam logic [1:0] FILT_STEP = 2'h1;

  // ========================================================
  // Transfer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADR, ST_OFFS, ST_WDAT, ST_ACK, ST_RDAT, ST_RACK
  } pirs_state_t;

  // Offset belongs to a two-byte register
  function automatic logic pirs_is_multi(input logic [PAGE_W-1:0] page,
                                         input logic [OFF_W-1:0] off);
    pirs_is_multi = (page == MB_PAGE) && (off < MB_END);
  endfunction : pirs_is_multi
endpackage : pirs_pkg

/* design/pirs_i2c_slave.sv */
`timescale 1ns/1ps
module pirs_i2c_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Board address straps
  input wire logic slave_addr_strap_bit2,
  input wire logic slave_addr_strap_bit1,
  input wire logic slave_addr_strap_bit0,
  // Boot loader status
  input wire logic boot_load_busy,
  // Status
  output logic [pirs_pkg::PAGE_W-1:0] page_select,
  output logic bus_active
);
  import pirs_pkg::*;

  // ========================================================
  // Input synchronisers and spike filters
  logic [1:0] raw_in;
  logic [1:0] syncd;
  logic [1:0] filt;
  logic [STRAP_W-1:0] strap_s1_ff, strap_s2_ff;
  assign raw_in = {sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_filt
      logic s1_ff, s2_ff, f_ff, nxt_f;
      logic [1:0] cnt_ff, nxt_cnt;
      // A change must persist two samples, so one sample of spike never passes
      always_comb
      begin
        nxt_cnt = 2'h0;
        nxt_f = f_ff;
        if (s2_ff != f_ff)
        begin
          if (cnt_ff == FILT_LIMIT)
            nxt_f = s2_ff;
          else
            nxt_cnt = cnt_ff + FILT_STEP;
        end
      end
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          s1_ff <= IDLE_LVL;
          s2_ff <= IDLE_LVL;
          f_ff <= IDLE_LVL;
          cnt_ff <= 2'h0;
        end
        else
        begin
          s1_ff <= raw_in[gi];
          s2_ff <= s1_ff;
          f_ff <= nxt_f;
          cnt_ff <= nxt_cnt;
        end
      end
      assign syncd[gi] = s2_ff;
      assign filt[gi] = f_ff;
    end
  endgenerate

  // Straps are static but still synchronised
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_s1_ff <= 3'h0;
      strap_s2_ff <= 3'h0;
    end
    else
    begin
      strap_s1_ff <= {slave_addr_strap_bit2, slave_addr_strap_bit1, slave_addr_strap_bit0};
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // ========================================================
  // Bus conditions; a few cycles of lag is small against a 1.3 us low phase
  logic scl_q_ff, sda_q_ff;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = filt[0] && !scl_q_ff;
  assign scl_fall = !filt[0] && scl_q_ff;
  assign start_c = filt[0] && scl_q_ff && sda_q_ff && !filt[1];
  assign stop_c = filt[0] && scl_q_ff && !sda_q_ff && filt[1];

  // ========================================================
  // Register storage, one array of pages
  logic [7:0] mem [0:NUM_PAGES*PAGE_BYTES-1];
  logic mem_we, mem_we2;
  logic [MEM_W-1:0] mem_wa, mem_wa2;
  logic [7:0] mem_wd, mem_wd2;

  // Protocol state
  pirs_state_t state_ff, nxt_state, ret_ff, nxt_ret;
  logic [3:0] bitcnt_ff, nxt_bitcnt;
  logic [7:0] shift_ff, nxt_shift, page_ff, nxt_page;
  logic [OFF_W-1:0] ptr_ff, nxt_ptr;
  logic oe_ff, nxt_oe, active_ff, nxt_active, sda_out_ff;
  logic [7:0] hold_ff, nxt_hold, shadow_ff, nxt_shadow, rd_val;
  logic hold_vld_ff, nxt_hold_vld, shadow_vld_ff, nxt_shadow_vld;
  logic [OFF_W-1:0] hold_off_ff, nxt_hold_off, shadow_off_ff, nxt_shadow_off;
  logic wr_fire, load_fire;

  // Active page selects the array row
  function automatic logic [MEM_W-1:0] mem_idx(input logic [OFF_W-1:0] off);
    mem_idx = {page_ff[PAGE_IDX_W-1:0], off};
  endfunction : mem_idx

  // Read path: page pointer, captured high byte, or storage
  function automatic logic [7:0] rd_byte(input logic [OFF_W-1:0] off);
    rd_byte = mem[mem_idx(off)];
    if (off == PAGE_PTR_OFF)
      rd_byte = page_ff;
    else if (shadow_vld_ff && (off == shadow_off_ff))
      rd_byte = shadow_ff;
  endfunction : rd_byte

  // ========================================================
  // Next-state logic
  always_comb
  begin
    nxt_state = state_ff;
    nxt_ret = ret_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shift = shift_ff;
    nxt_page = page_ff;
    nxt_ptr = ptr_ff;
    nxt_oe = oe_ff;
    nxt_active = active_ff;
    nxt_hold = hold_ff;
    nxt_hold_vld = hold_vld_ff;
    nxt_hold_off = hold_off_ff;
    nxt_shadow = shadow_ff;
    nxt_shadow_vld = shadow_vld_ff;
    nxt_shadow_off = shadow_off_ff;
    wr_fire = 1'b0;
    load_fire = 1'b0;
    mem_we = 1'b0;
    mem_we2 = 1'b0;
    mem_wa = mem_idx(ptr_ff);
    mem_wa2 = mem_idx(ptr_ff);
    mem_wd = shift_ff;
    mem_wd2 = shift_ff;
    rd_val = rd_byte(ptr_ff);
    if (start_c)
    begin
      nxt_state = ST_DEVADR;
      nxt_bitcnt = 4'h0;
      nxt_oe = 1'b0;
      nxt_active = 1'b1;
    end
    else if (stop_c)
    begin
      nxt_state = ST_IDLE;
      nxt_oe = 1'b0;
      nxt_active = 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
          nxt_oe = 1'b0;
        ST_DEVADR, ST_OFFS, ST_WDAT:
          if (scl_rise)
          begin
            nxt_shift = {shift_ff[6:0], filt[1]};
            nxt_bitcnt = bitcnt_ff + BIT_STEP;
          end
          else if (scl_fall && (bitcnt_ff == BYTE_BITS))
          begin
            nxt_state = ST_ACK;
            nxt_oe = 1'b1;
            nxt_ret = ST_WDAT;
            if (state_ff == ST_DEVADR)
            begin
              if ((shift_ff[7:4] != ADDR_PREFIX)
                  || (shift_ff[3:1] != strap_s2_ff)
                  || boot_load_busy)
              begin
                nxt_oe = 1'b0;
                nxt_state = ST_IDLE;
              end
              else
                nxt_ret = shift_ff[0] ? ST_RDAT : ST_OFFS;
            end
            else if (state_ff == ST_OFFS)
              nxt_ptr = shift_ff[OFF_W-1:0];
            else
            begin
              wr_fire = 1'b1;
              nxt_ptr = ptr_ff + OFF_STEP;
            end
          end
        ST_ACK:
          if (scl_fall)
          begin
            nxt_bitcnt = 4'h0;
            nxt_state = ret_ff;
            nxt_oe = 1'b0;
            load_fire = (ret_ff == ST_RDAT);
          end
        ST_RDAT:
          if (scl_rise)
            nxt_bitcnt = bitcnt_ff + BIT_STEP;
          else if (scl_fall)
          begin
            if (bitcnt_ff == BYTE_BITS)
            begin
              nxt_oe = 1'b0;
              nxt_state = ST_RACK;
            end
            else
            begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_oe = !shift_ff[6];
            end
          end
        ST_RACK:
          // Reload only on the fall: SDA must not move while SCL is high
          if (scl_rise && filt[1])
            nxt_state = ST_IDLE;
          else if (scl_fall)
          begin
            load_fire = 1'b1;
            nxt_state = ST_RDAT;
            nxt_bitcnt = 4'h0;
          end
        default:
          nxt_state = ST_IDLE;
      endcase
    end
    // Byte fetch for the master; pointer always ends one past the last byte
    if (load_fire)
    begin
      nxt_shift = rd_val;
      nxt_oe = !rd_val[7];
      nxt_ptr = ptr_ff + OFF_STEP;
      nxt_shadow_vld = 1'b0;
      if (pirs_is_multi(page_ff, ptr_ff) && !ptr_ff[0])
      begin
        nxt_shadow = mem[mem_idx(ptr_ff + OFF_STEP)];
        nxt_shadow_vld = 1'b1;
        nxt_shadow_off = ptr_ff + OFF_STEP;
      end
    end
    // Byte store: page pointer, pending low byte, or plain register
    if (wr_fire)
    begin
      if (ptr_ff == PAGE_PTR_OFF)
        nxt_page = shift_ff;
      else if (pirs_is_multi(page_ff, ptr_ff))
      begin
        nxt_hold_vld = 1'b0;
        if (!ptr_ff[0])
        begin
          nxt_hold = shift_ff;
          nxt_hold_vld = 1'b1;
          nxt_hold_off = ptr_ff;
        end
        else if (hold_vld_ff && (hold_off_ff[OFF_W-1:1] == ptr_ff[OFF_W-1:1]))
        begin
          // Commit both halves only after the last byte arrives
          mem_we = 1'b1;
          mem_wa = mem_idx(hold_off_ff);
          mem_wd = hold_ff;
          mem_we2 = 1'b1;
        end
      end
      else
      begin
        mem_we = 1'b1;
        nxt_hold_vld = 1'b0;
      end
    end
  end

  // ========================================================
  // State registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_IDLE;
      ret_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      page_ff <= PAGE_RESET;
      ptr_ff <= 7'h00;
      oe_ff <= 1'b0;
      active_ff <= 1'b0;
      sda_out_ff <= DRIVE_LVL;
      hold_ff <= 8'h00;
      hold_vld_ff <= 1'b0;
      hold_off_ff <= 7'h00;
      shadow_ff <= 8'h00;
      shadow_vld_ff <= 1'b0;
      shadow_off_ff <= 7'h00;
      scl_q_ff <= IDLE_LVL;
      sda_q_ff <= IDLE_LVL;
    end
    else
    begin
      state_ff <= nxt_state;
      ret_ff <= nxt_ret;
      bitcnt_ff <= nxt_bitcnt;
      shift_ff <= nxt_shift;
      page_ff <= nxt_page;
      ptr_ff <= nxt_ptr;
      oe_ff <= nxt_oe;
      active_ff <= nxt_active;
      sda_out_ff <= DRIVE_LVL;
      hold_ff <= nxt_hold;
      hold_vld_ff <= nxt_hold_vld;
      hold_off_ff <= nxt_hold_off;
      shadow_ff <= nxt_shadow;
      shadow_vld_ff <= nxt_shadow_vld;
      shadow_off_ff <= nxt_shadow_off;
      scl_q_ff <= filt[0];
      sda_q_ff <= filt[1];
    end
  end

  // Storage has no reset; contents are defined by writes only
  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
    if (mem_we2)
      mem[mem_wa2] <= mem_wd2;
  end

  assign sda_out = sda_out_ff;
  assign sda_oe = oe_ff;
  assign page_select = page_ff;
  assign bus_active = active_ff;

  // ========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic adr_done;
  assign adr_done = scl_fall && (state_ff == ST_DEVADR) && (bitcnt_ff == BYTE_BITS);

  property p_prefix;
    adr_done && !start_c && !stop_c && (shift_ff[7:4] != ADDR_PREFIX) |=> !oe_ff;
  endproperty
  a_prefix: assert property (p_prefix) else $error("ack on wrong prefix");
  property p_strap;
    adr_done && !start_c && !stop_c && (shift_ff[3:1] != strap_s2_ff) |=> !oe_ff;
  endproperty
  a_strap: assert property (p_strap) else $error("ack on wrong strap bits");
  property p_boot;
    adr_done && !start_c && !stop_c && boot_load_busy |=> !oe_ff ##1 state_ff == ST_IDLE;
  endproperty
  a_boot: assert property (p_boot) else $error("answered during boot load");
  property p_spike;
    $changed(filt[0]) |-> ($past(syncd[0], 1) == filt[0]) && ($past(syncd[0], 2) == filt[0]);
  endproperty
  a_spike: assert property (p_spike) else $error("short pulse passed filter");
  property p_wrap;
    load_fire && (ptr_ff == PAGE_PTR_OFF) |=> ptr_ff == 7'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
  property p_rdinc;
    load_fire |=> (ptr_ff == $past(ptr_ff) + OFF_STEP) && (shift_ff == $past(rd_val));
  endproperty
  a_rdinc: assert property (p_rdinc) else $error("read fetch wrong");
  property p_wrinc;
    wr_fire |=> ptr_ff == $past(ptr_ff) + OFF_STEP;
  endproperty
  a_wrinc: assert property (p_wrinc) else $error("write pointer not advanced");
  property p_page;
    wr_fire && (ptr_ff == PAGE_PTR_OFF) |=> (page_select == $past(shift_ff)) && !mem_we;
  endproperty
  a_page: assert property (p_page) else $error("page pointer not taken");
  property p_pend;
    wr_fire && pirs_is_multi(page_ff, ptr_ff) && !ptr_ff[0] |-> !mem_we ##1 hold_vld_ff;
  endproperty
  a_pend: assert property (p_pend) else $error("low byte took effect early");
  property p_snap;
    load_fire && pirs_is_multi(page_ff, ptr_ff) && !ptr_ff[0] |=> shadow_vld_ff
      && (shadow_off_ff == ptr_ff);
  endproperty
  a_snap: assert property (p_snap) else $error("high byte not captured");

  c_cur_read: cover property (state_ff == ST_ACK && ret_ff == ST_RDAT ##[1:60] load_fire);
  c_page_wr: cover property (wr_fire && ptr_ff == PAGE_PTR_OFF);
  c_commit: cover property (mem_we && mem_we2);
  c_wrap: cover property (load_fire && ptr_ff == PAGE_PTR_OFF);
endmodule : pirs_i2c_slave

/* test/pirs_master_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Bus master model: drives SCL, pulls SDA low, never stretches
module pirs_master_model #(
  // Half SCL period in core cycles: 357 kHz keeps the 13-cycle low minimum
  parameter int HALF = 14
) (
  // Clock and bus lines
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_pull,
  // One pulse per byte: ack bit or read data
  output logic res_valid,
  output logic [7:0] res_data
);
  logic spike_en;

  // Idle bus, both lines released
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
    res_valid = 1'b0;
    res_data = 8'h00;
    spike_en = 1'b0;
  end

  // ========================================================
  // Bus primitives, all moves at the falling core edge except the optional spikes
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask : hw

  // One bit; optional 40 ns spikes on both lines while SCL is high
  // Each spike straddles a core rising edge, so exactly one sample sees it
  task automatic bit_io(input logic b, output logic seen);
    hw(HALF / 2);
    sda_pull = !b;
    hw(HALF / 2);
    scl = 1'b1;
    hw(HALF / 2);
    seen = sda_wire;
    if (spike_en)
    begin
      #30 scl = 1'b0;
      #40 scl = 1'b1;
      #60 sda_pull = !sda_pull;
      #40 sda_pull = !sda_pull;
    end
    hw(HALF / 2);
    scl = 1'b0;
  endtask : bit_io

  task automatic report(input logic [7:0] v);
    res_data = v;
    res_valid = 1'b1;
    @(negedge clk);
    res_valid = 1'b0;
  endtask : report

  // Start or repeated start, ends with SCL low
  task automatic start();
    hw(HALF / 2);
    sda_pull = 1'b0;
    hw(HALF / 2);
    scl = 1'b1;
    hw(HALF);
    sda_pull = 1'b1;
    hw(HALF);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    hw(HALF / 2);
    sda_pull = 1'b1;
    hw(HALF / 2);
    scl = 1'b1;
    hw(HALF);
    sda_pull = 1'b0;
    hw(HALF);
  endtask : stop

  // Byte out, most significant bit first, then the ack bit
  task automatic wr_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    report({7'h00, s});
  endtask : wr_byte

  // Byte in; a nack on the last byte ends the read
  task automatic rd_byte(input logic last);
    logic [7:0] v;
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(last, s);
    report(v);
  endtask : rd_byte
endmodule : pirs_master_model

/* test/pirs_i2c_slave_bench.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the paged register slave
module pirs_i2c_slave_bench;
  import pirs_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic boot_load_busy = 1'b0;
  logic [2:0] strap = 3'h0;
  logic scl, sda_pull, sda_out, sda_oe, sda_wire, bus_active, res_valid;
  logic [7:0] res_data;
  logic [PAGE_W-1:0] page_select;
  logic [7:0] exp_q[$];
  logic [7:0] w[16];
  int n_fail = 0;
  int total_checks = 0;
  int seed = 77;
  int cycles = 0;

  always #50 clk = !clk;
  // Open-drain wire with pull-up
  assign sda_wire = !sda_pull && !(sda_oe && !sda_out);

  pirs_i2c_slave DUT (
    .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .slave_addr_strap_bit2(strap[2]),
    .slave_addr_strap_bit1(strap[1]), .slave_addr_strap_bit0(strap[0]),
    .boot_load_busy(boot_load_busy), .page_select(page_select), .bus_active(bus_active)
  );
  pirs_master_model M (
    .clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull),
    .res_valid(res_valid), .res_data(res_data)
  );

  // ========================================================
  // Compare and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Each reported byte takes the oldest note; watchdog bounds the run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (res_valid)
      check(res_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
    if (cycles > 100000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // ========================================================
  // Transfer helpers; expectations noted before each byte
  task automatic dev(input logic [3:0] pre, input logic [2:0] st, input logic r,
                     input logic [7:0] ack);
    M.start();
    exp_q.push_back(ack);
    M.wr_byte({pre, st, r});
  endtask : dev

  task automatic wr(input logic [7:0] v);
    exp_q.push_back(8'h00);
    M.wr_byte(v);
  endtask : wr

  // Burst write from offset, bytes taken from w[base]
  task automatic write_at(input logic [7:0] off, input int base, input int n);
    dev(ADDR_PREFIX, strap, 1'b0, 8'h00);
    wr(off);
    for (int i = 0; i < n; i++)
      wr(w[base+i]);
    check({7'h00, bus_active}, 8'h01);
    M.stop();
    check({7'h00, bus_active}, 8'h00);
  endtask : write_at

  // Burst read, with offset set first or from the current pointer
  task automatic read_at(input logic [7:0] off, input int base, input int n, input logic use_off);
    if (use_off)
    begin
      dev(ADDR_PREFIX, strap, 1'b0, 8'h00);
      wr(off);
    end
    dev(ADDR_PREFIX, strap, 1'b1, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(w[base+i]);
      M.rd_byte(i == n - 1);
    end
    M.stop();
  endtask : read_at

  // ========================================================
  // Main sequence
  initial
  begin
    strap = 3'($random(seed));
    for (int i = 0; i < 16; i++)
      w[i] = 8'($random(seed));
    w[5] = 8'h00;
    w[7] = 8'h01;
    w[9] = 8'h00;
    w[10] = 8'h02;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    check(page_select, PAGE_RESET);
    check({7'h00, bus_active}, 8'h00);
    // Foreign prefix, each wrong strap bit, and boot load all refused
    dev(4'h5, strap, 1'b0, 8'h01);
    M.stop();
    for (int k = 0; k < 3; k++)
    begin
      dev(ADDR_PREFIX, strap ^ 3'(1 << k), 1'b0, 8'h01);
      M.stop();
    end
    boot_load_busy = 1'b1;
    dev(ADDR_PREFIX, strap, 1'b0, 8'h01);
    M.stop();
    boot_load_busy = 1'b0;
    // Burst write under spikes, offset read, then current-address read
    M.spike_en = 1'b1;
    write_at(8'h10, 0, 4);
    M.spike_en = 1'b0;
    read_at(8'h10, 0, 2, 1'b1);
    read_at(8'h00, 2, 2, 1'b0);
    // Burst across the pointer location wraps to offset zero
    write_at(8'h7E, 4, 3);
    read_at(8'h7E, 4, 3, 1'b1);
    // Page 1 has its own storage; pointer reads back
    write_at(8'h7F, 7, 1);
    check(page_select, 8'h01);
    write_at(8'h10, 8, 1);
    read_at(8'h10, 8, 1, 1'b1);
    read_at(8'h7F, 7, 1, 1'b1);
    write_at(8'h7F, 9, 1);
    read_at(8'h10, 0, 1, 1'b1);
    // Two-byte register: lone low byte stays pending
    write_at(8'h7F, 10, 1);
    write_at(8'h00, 11, 2);
    read_at(8'h00, 11, 2, 1'b1);
    write_at(8'h00, 13, 1);
    read_at(8'h00, 11, 2, 1'b1);
    write_at(8'h00, 13, 2);
    read_at(8'h00, 13, 2, 1'b1);
    repeat (4) @(negedge clk);
    check(8'(exp_q.size()), 8'h00);
    end_sim();
  end
endmodule : pirs_i2c_slave_bench
